// ### cdic_pkg.sv
// Constants, types and helpers shared by the cascaded interrupt controller.
`default_nettype none
package cdic_pkg;

    localparam int unsigned NCTRL = 2;
    localparam int unsigned NCH = 8;
    localparam int unsigned CH_W = 3;
    localparam int unsigned MASTER = 0;
    localparam int unsigned SLAVE = 1;
    localparam int unsigned NEXT_REQ = 16;

    localparam logic [7:0] MASTER_BASE = 8'h20;
    localparam logic [7:0] SLAVE_BASE = 8'hA0;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    localparam logic [2:0] CAS_CH = 3'h2;
    localparam logic [2:0] SPURIOUS_CH = 3'h7;
    localparam logic [2:0] LOW_DEFAULT = 3'h7;
    localparam logic [7:0] CAS_CFG_DEFAULT = 8'h07;

    localparam int unsigned INIT_FLAG_BIT = 4;
    localparam int unsigned SINGLE_BIT = 1;
    localparam int unsigned LEVEL_BIT = 3;
    localparam int unsigned AUTO_EOS_BIT = 1;
    localparam int unsigned MULTI_NEST_BIT = 4;
    localparam int unsigned OCW_KIND_BIT = 3;
    localparam int unsigned VEC_HI = 7;
    localparam int unsigned VEC_LO = 3;
    localparam int unsigned CMD_HI = 7;
    localparam int unsigned CMD_LO = 5;
    localparam int unsigned SMM_HI = 6;
    localparam int unsigned SMM_LO = 5;
    localparam int unsigned RSEL_HI = 1;
    localparam int unsigned RSEL_LO = 0;
    localparam int unsigned LVL_HI = 2;
    localparam int unsigned LVL_LO = 0;

    localparam logic [1:0] SMM_SET = 2'b11;
    localparam logic [1:0] SMM_CLR = 2'b10;
    localparam logic [1:0] RSEL_REQ = 2'b10;
    localparam logic [1:0] RSEL_SVC = 2'b11;

    typedef enum logic [1:0] {
        INIT_DONE = 2'b00,
        INIT_VEC = 2'b01,
        INIT_CAS = 2'b10,
        INIT_MODE = 2'b11
    } cdic_init_t;

    typedef enum logic [2:0] {
        CMD_ROT_AUTO_CLR = 3'b000,
        CMD_NS_EOS = 3'b001,
        CMD_NOP = 3'b010,
        CMD_SP_EOS = 3'b011,
        CMD_ROT_AUTO_SET = 3'b100,
        CMD_ROT_NS_EOS = 3'b101,
        CMD_SET_PRIO = 3'b110,
        CMD_ROT_SP_EOS = 3'b111
    } cdic_cmd_t;

    typedef enum logic {
        ACK_FIRST = 1'b0,
        ACK_SECOND = 1'b1
    } cdic_ack_t;

    typedef struct packed {
        logic [7:0] req_latch;
        logic [7:0] in_service;
        logic [7:0] chan_mask;
        logic [7:0] prev_in;
        logic [4:0] vec_base;
        logic [7:0] cas_cfg;
        cdic_init_t init_step;
        logic single;
        logic level;
        logic auto_eos;
        logic multi_nest;
        logic smm;
        logic rd_svc;
        logic rot_auto;
        logic [2:0] low;
        logic [2:0] serv_idx;
        logic served;
        logic irq;
    } cdic_ctrl_t;

    typedef struct packed {
        cdic_ctrl_t [NCTRL-1:0] ctrl;
        cdic_ack_t ack_phase;
        logic resp_slave;
        logic [2:0] cas_addr;
        logic [7:0] vec;
        logic vec_oe_n;
        logic [7:0] rdata;
    } cdic_state_t;

    localparam cdic_ctrl_t CTRL_RST = '{
        req_latch: 8'h00, in_service: 8'h00, chan_mask: 8'h00,
        prev_in: 8'h00, vec_base: 5'h00, cas_cfg: CAS_CFG_DEFAULT,
        init_step: INIT_DONE, single: 1'b1, level: 1'b0,
        auto_eos: 1'b0, multi_nest: 1'b0, smm: 1'b0, rd_svc: 1'b0,
        rot_auto: 1'b0, low: LOW_DEFAULT, serv_idx: 3'h0,
        served: 1'b0, irq: 1'b0};

    localparam cdic_state_t STATE_RST = '{
        ctrl: {CTRL_RST, CTRL_RST}, ack_phase: ACK_FIRST,
        resp_slave: 1'b0, cas_addr: 3'h0, vec: 8'h00,
        vec_oe_n: 1'b1, rdata: 8'h00};

    // Rank 0 is the highest priority; the channel after low ranks first.
    function automatic logic [2:0] rank(input logic [2:0] idx,
                                        input logic [2:0] low);
        rank = 3'(idx - low - 3'h1);
    endfunction : rank

    function automatic logic hits(input logic [7:0] addr,
                                  input logic [7:0] base);
        hits = (addr[7:1] == base[7:1]);
    endfunction : hits

endpackage : cdic_pkg
`default_nettype wire

// ### cdic_prio.sv
// Rotating priority encoder: finds the highest ranked set bit of a vector.
`timescale 1ns/1ps
`default_nettype none
module cdic_prio (
    input wire logic [cdic_pkg::NCH-1:0] i_vec,
    input wire logic [cdic_pkg::CH_W-1:0] i_low,
    output logic o_valid,
    output logic [cdic_pkg::CH_W-1:0] o_idx
);
    import cdic_pkg::*;

    logic [CH_W-1:0] cand;

    // Scanning from the lowest rank up lets the highest rank overwrite last.
    always_comb begin
        o_valid = 1'b0;
        o_idx = i_low;
        cand = i_low;
        for (int j = NCH - 1; j >= 0; j--) begin
            cand = 3'(i_low + 3'(j + 1));
            if (i_vec[cand]) begin
                o_valid = 1'b1;
                o_idx = cand;
            end
        end
    end

endmodule : cdic_prio
`default_nettype wire

// ### cdic_top.sv
// Master and slave interrupt controllers joined in a fixed cascade.
//
// What this block does
// - Slave interrupt output feeds master request channel 2 internally.
// - Master answers at I/O pair 020H-021H, slave at 0A0H-0A1H.
// - Timer 0 drives master channel 0; real-time clock drives slave 0.
// - Fifteen channels; all others come from external request pins.
// - An active channel request sets its request latch bit.
// - Mask register disables any or all channels from raising interrupt.
// - Several in-service bits may be set together.
// - Resolver combines request, mask, in-service; interrupt only if deserved.
// - First acknowledge sets in-service, clears request, makes cascade code.
// - Second acknowledge drives vector: base in bits 7..3, channel below.
// - Slave compares master's cascade code with its 3-bit identity.
// - Automatic end clears in-service after second acknowledge, else command.
// - No pending request at first acknowledge gives the level 7 vector.
// - Specific end clears named bit; non-specific clears highest set bit.
// - Special mask mode: non-specific end skips masked in-service bits.
// - Priority mode may change any time without a reset.
// - Default fixed priority: channel 0 highest, channel 7 lowest.
// - In-service blocks equal and lower priority, higher still raises.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cdic_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_timer0,
    input wire logic i_rtc_irq,
    input wire logic [cdic_pkg::NEXT_REQ-1:0] i_ext_req,
    input wire logic i_ack,
    output logic o_cpu_irq,
    output logic [7:0] o_vec_data,
    output logic o_vec_oe_n,
    output logic [2:0] o_cas_addr
);
    import cdic_pkg::*;

    cdic_state_t s_q;
    cdic_state_t s_d;

    logic [NCTRL-1:0][NCH-1:0] chan_in;
    logic [NCTRL-1:0][NCH-1:0] req_view;
    logic [NCTRL-1:0][NCH-1:0] svc_view;
    logic [NCTRL-1:0] pend_valid;
    logic [NCTRL-1:0][CH_W-1:0] pend_idx;
    logic [NCTRL-1:0] svc_valid;
    logic [NCTRL-1:0][CH_W-1:0] svc_idx;
    logic [NCTRL-1:0] win;
    logic [NCTRL-1:0] sel;
    logic [NCTRL-1:0][NCH-1:0] rise;
    logic [NCTRL-1:0][NCH-1:0] req_clr;
    logic [NCTRL-1:0][NCH-1:0] svc_clr;
    logic [NCTRL-1:0][NCH-1:0] svc_set;
    logic first_ack;
    logic second_ack;
    logic m_cascade;
    logic s_match;
    logic [CH_W-1:0] lvl;
    cdic_cmd_t cmd;

    // Channel wiring is fixed; the master's channel 2 sees the slave's
    // registered request, so the cascade link is one clock behind the slave.
    assign chan_in[MASTER] = {i_ext_req[7:3], s_q.ctrl[SLAVE].irq,
                              i_ext_req[1], i_timer0};
    assign chan_in[SLAVE] = {i_ext_req[15:9], i_rtc_irq};

    for (genvar k = 0; k < NCTRL; k++) begin : g_ctrl
        assign req_view[k] = s_q.ctrl[k].req_latch
                             & ~s_q.ctrl[k].chan_mask;
        assign svc_view[k] = s_q.ctrl[k].smm
                             ? (s_q.ctrl[k].in_service
                                & ~s_q.ctrl[k].chan_mask)
                             : s_q.ctrl[k].in_service;
        cdic_prio u_pend (
            .i_vec(req_view[k]),
            .i_low(s_q.ctrl[k].low),
            .o_valid(pend_valid[k]),
            .o_idx(pend_idx[k])
        );
        cdic_prio u_svc (
            .i_vec(svc_view[k]),
            .i_low(s_q.ctrl[k].low),
            .o_valid(svc_valid[k]),
            .o_idx(svc_idx[k])
        );
    end

    assign first_ack = i_ack && (s_q.ack_phase == ACK_FIRST);
    assign second_ack = i_ack && (s_q.ack_phase == ACK_SECOND);
    assign cmd = cdic_cmd_t'(i_wdata[CMD_HI:CMD_LO]);
    assign lvl = i_wdata[LVL_HI:LVL_LO];

    always_comb begin
        s_d = s_q;
        s_d.vec_oe_n = 1'b1;
        s_d.rdata = UNMAPPED_DATA;
        rise = '0;
        req_clr = '0;
        svc_clr = '0;
        svc_set = '0;
        win = '0;
        sel[MASTER] = hits(i_addr, MASTER_BASE);
        sel[SLAVE] = hits(i_addr, SLAVE_BASE);

        // A request deserves service only above every in-service level, or every
        // unmasked one in special mask mode; equal level passes only for a nested cascade input.
        for (int k = 0; k < NCTRL; k++) begin
            win[k] = pend_valid[k] && (!svc_valid[k]
                     || (rank(pend_idx[k], s_q.ctrl[k].low)
                         < rank(svc_idx[k], s_q.ctrl[k].low))
                     || (s_q.ctrl[k].multi_nest
                         && pend_idx[k] == svc_idx[k]
                         && !s_q.ctrl[k].single
                         && s_q.ctrl[k].cas_cfg[pend_idx[k]]));
            s_d.ctrl[k].irq = win[k];
            rise[k] = chan_in[k] & ~s_q.ctrl[k].prev_in;
            s_d.ctrl[k].prev_in = chan_in[k];
        end

        m_cascade = win[MASTER] && !s_q.ctrl[MASTER].single
                    && s_q.ctrl[MASTER].cas_cfg[pend_idx[MASTER]];
        s_match = m_cascade
                  && (s_q.ctrl[SLAVE].cas_cfg[CH_W-1:0]
                      == pend_idx[MASTER]);

        // First acknowledge: resolve, move request into service, keep the
        // data pins released.
        if (first_ack) begin
            s_d.ack_phase = ACK_SECOND;
            s_d.resp_slave = s_match;
            s_d.cas_addr = pend_idx[MASTER];
            for (int k = 0; k < NCTRL; k++) begin
                s_d.ctrl[k].served = 1'b0;
            end
            if (win[MASTER]) begin
                svc_set[MASTER][pend_idx[MASTER]] = 1'b1;
                req_clr[MASTER][pend_idx[MASTER]] = 1'b1;
                s_d.ctrl[MASTER].serv_idx = pend_idx[MASTER];
                s_d.ctrl[MASTER].served = 1'b1;
            end else begin
                s_d.ctrl[MASTER].serv_idx = SPURIOUS_CH;
            end
            if (s_match) begin
                if (win[SLAVE]) begin
                    svc_set[SLAVE][pend_idx[SLAVE]] = 1'b1;
                    req_clr[SLAVE][pend_idx[SLAVE]] = 1'b1;
                    s_d.ctrl[SLAVE].serv_idx = pend_idx[SLAVE];
                    s_d.ctrl[SLAVE].served = 1'b1;
                end else begin
                    s_d.ctrl[SLAVE].serv_idx = SPURIOUS_CH;
                end
            end
        end

        // Second acknowledge: present the vector for one cycle and, on the
        // same clock edge, end service automatically where that is selected.
        if (second_ack) begin
            s_d.ack_phase = ACK_FIRST;
            s_d.vec_oe_n = 1'b0;
            if (s_q.resp_slave) begin
                s_d.vec = {s_q.ctrl[SLAVE].vec_base,
                           s_q.ctrl[SLAVE].serv_idx};
            end else begin
                s_d.vec = {s_q.ctrl[MASTER].vec_base,
                           s_q.ctrl[MASTER].serv_idx};
            end
            for (int k = 0; k < NCTRL; k++) begin
                if (s_q.ctrl[k].served && s_q.ctrl[k].auto_eos) begin
                    svc_clr[k][s_q.ctrl[k].serv_idx] = 1'b1;
                    if (s_q.ctrl[k].rot_auto) begin
                        s_d.ctrl[k].low = s_q.ctrl[k].serv_idx;
                    end
                end
            end
        end

        for (int k = 0; k < NCTRL; k++) begin
            if (i_wr && sel[k]) begin
                if (!i_addr[0] && i_wdata[INIT_FLAG_BIT]) begin
                    s_d.ctrl[k].init_step = INIT_VEC;
                    s_d.ctrl[k].single = i_wdata[SINGLE_BIT];
                    s_d.ctrl[k].level = i_wdata[LEVEL_BIT];
                    s_d.ctrl[k].low = LOW_DEFAULT;
                    s_d.ctrl[k].chan_mask = 8'h00;
                    s_d.ctrl[k].cas_cfg = CAS_CFG_DEFAULT;
                    s_d.ctrl[k].smm = 1'b0;
                    s_d.ctrl[k].rd_svc = 1'b0;
                    s_d.ctrl[k].rot_auto = 1'b0;
                end else if (!i_addr[0] && i_wdata[OCW_KIND_BIT]) begin
                    s_d.ctrl[k].init_step = INIT_DONE;
                    if (i_wdata[SMM_HI:SMM_LO] == SMM_SET) begin
                        s_d.ctrl[k].smm = 1'b1;
                    end else if (i_wdata[SMM_HI:SMM_LO] == SMM_CLR) begin
                        s_d.ctrl[k].smm = 1'b0;
                    end
                    if (i_wdata[RSEL_HI:RSEL_LO] == RSEL_REQ) begin
                        s_d.ctrl[k].rd_svc = 1'b0;
                    end else if (i_wdata[RSEL_HI:RSEL_LO] == RSEL_SVC) begin
                        s_d.ctrl[k].rd_svc = 1'b1;
                    end
                end else if (!i_addr[0]) begin
                    s_d.ctrl[k].init_step = INIT_DONE;
                    // Mode commands act at once, with no reinitialisation.
                    unique case (cmd)
                        CMD_ROT_AUTO_CLR: s_d.ctrl[k].rot_auto = 1'b0;
                        CMD_ROT_AUTO_SET: s_d.ctrl[k].rot_auto = 1'b1;
                        CMD_NOP: ;
                        CMD_NS_EOS: begin
                            if (svc_valid[k]) begin
                                svc_clr[k][svc_idx[k]] = 1'b1;
                            end
                        end
                        CMD_ROT_NS_EOS: begin
                            if (svc_valid[k]) begin
                                svc_clr[k][svc_idx[k]] = 1'b1;
                                s_d.ctrl[k].low = svc_idx[k];
                            end
                        end
                        CMD_SP_EOS: svc_clr[k][lvl] = 1'b1;
                        CMD_ROT_SP_EOS: begin
                            svc_clr[k][lvl] = 1'b1;
                            s_d.ctrl[k].low = lvl;
                        end
                        CMD_SET_PRIO: s_d.ctrl[k].low = lvl;
                    endcase
                end else begin
                    unique case (s_q.ctrl[k].init_step)
                        INIT_VEC: begin
                            s_d.ctrl[k].vec_base = i_wdata[VEC_HI:VEC_LO];
                            s_d.ctrl[k].init_step = INIT_CAS;
                        end
                        INIT_CAS: begin
                            s_d.ctrl[k].cas_cfg = i_wdata;
                            s_d.ctrl[k].init_step = INIT_MODE;
                        end
                        INIT_MODE: begin
                            s_d.ctrl[k].auto_eos = !i_wdata[AUTO_EOS_BIT];
                            s_d.ctrl[k].multi_nest = i_wdata[MULTI_NEST_BIT];
                            s_d.ctrl[k].init_step = INIT_DONE;
                        end
                        INIT_DONE: s_d.ctrl[k].chan_mask = i_wdata;
                    endcase
                end
            end

            if (i_rd && sel[k]) begin
                if (i_addr[0]) begin
                    s_d.rdata = s_q.ctrl[k].chan_mask;
                end else if (s_q.ctrl[k].rd_svc) begin
                    s_d.rdata = s_q.ctrl[k].in_service;
                end else begin
                    s_d.rdata = s_q.ctrl[k].req_latch;
                end
            end

            // A fresh edge in the acknowledge cycle survives the clear, and
            // a bit set by acknowledge survives a same-cycle end command.
            if (s_q.ctrl[k].level) begin
                s_d.ctrl[k].req_latch = chan_in[k];
            end else begin
                s_d.ctrl[k].req_latch = (s_q.ctrl[k].req_latch & ~req_clr[k])
                                        | rise[k];
            end
            s_d.ctrl[k].in_service = (s_q.ctrl[k].in_service & ~svc_clr[k])
                                     | svc_set[k];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_cpu_irq = s_q.ctrl[MASTER].irq;
    assign o_vec_data = s_q.vec;
    assign o_vec_oe_n = s_q.vec_oe_n;
    assign o_cas_addr = s_q.cas_addr;
    assign o_rdata = s_q.rdata;

endmodule : cdic_top
`default_nettype wire

// ### cdic_checker.sv
// Port-level assertions for the cascaded interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module cdic_checker (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic i_rd,
    input wire logic i_ack,
    input wire logic [7:0] o_rdata,
    input wire logic o_cpu_irq,
    input wire logic [7:0] o_vec_data,
    input wire logic o_vec_oe_n,
    input wire logic [2:0] o_cas_addr
);
    logic ph_q;
    // Tracks which acknowledge of a pair comes next, so that the checks
    // tell the resolving cycle from the one that carries the vector.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ph_q <= 1'b0;
        end else if (i_ack) begin
            ph_q <= ~ph_q;
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    chk_vec_cause: assert property (
        !o_vec_oe_n |-> $past(i_ack) && $past(ph_q))
        else $error("vector driven without a second acknowledge");
    chk_ack2_vec: assert property (
        i_ack && ph_q |=> !o_vec_oe_n)
        else $error("second acknowledge gave no vector");
    chk_ack1_float: assert property (
        i_ack && !ph_q |=> o_vec_oe_n)
        else $error("data pins driven after first acknowledge");
    chk_ack1_irq_low: assert property (
        i_ack && !ph_q |=> ##1 !o_cpu_irq)
        else $error("interrupt still raised after first acknowledge");
    chk_vec_hold: assert property (
        o_vec_oe_n |-> $stable(o_vec_data))
        else $error("vector data moved outside a vector cycle");
    chk_cas_cause: assert property (
        $changed(o_cas_addr) |-> $past(i_ack) && !$past(ph_q))
        else $error("cascade code changed outside first acknowledge");
    chk_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_unmapped_rd: assert property (
        $past(i_rd) && $past(i_addr[7:1]) != 7'h10
        && $past(i_addr[7:1]) != 7'h50 |-> o_rdata == 8'h00)
        else $error("unmapped read returned data");
endmodule : cdic_checker
bind cdic_top cdic_checker u_chk (.i_sys_clk, .i_rst_n, .i_addr, .i_rd,
    .i_ack, .o_rdata, .o_cpu_irq, .o_vec_data, .o_vec_oe_n, .o_cas_addr);
`default_nettype wire

// ### cdic_cpu_model.sv
// Host processor model that answers interrupts with acknowledge pairs.
`timescale 1ns/1ps
`default_nettype none
module cdic_cpu_model (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_en,
    input wire logic i_slow,
    input wire logic i_spur,
    input wire logic i_cpu_irq,
    output logic o_ack
);
    logic [2:0] st_q;
    // A cool-down after each pair keeps a stale request level from
    // starting a second pair before the device has updated its output.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= 3'h0;
            o_ack <= 1'b0;
        end else begin
            o_ack <= 1'b0;
            if (st_q == 3'h0) begin
                if (i_spur || (i_en && i_cpu_irq)) begin
                    o_ack <= 1'b1;
                    st_q <= 3'h1;
                end
            end else begin
                o_ack <= (st_q == (i_slow ? 3'h4 : 3'h2));
                st_q <= (st_q == 3'h6) ? 3'h0 : st_q + 3'h1;
            end
        end
    end
endmodule : cdic_cpu_model
`default_nettype wire

// ### cdic_top_tb_top.sv
// Self-checking testbench for the cascaded interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module cdic_top_tb_top;
    import cdic_pkg::*;
    logic i_sys_clk, i_rst_n, i_wr, i_rd, i_ack, en, slow, spur;
    logic rd_q = 1'b0;
    logic o_cpu_irq, o_vec_oe_n;
    logic [2:0] o_cas_addr;
    logic [7:0] i_addr, i_wdata, o_rdata, o_vec_data, mb, sb;
    logic [17:0] req_q;
    logic [7:0] vq[$];
    logic [7:0] rq[$];
    integer seed = 32'h311A4D8B;
    int miscompares = 0;
    int n_tests = 0;
    cdic_top dut (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
        .o_rdata, .i_timer0(req_q[16]), .i_rtc_irq(req_q[17]),
        .i_ext_req(req_q[15:0]), .i_ack, .o_cpu_irq, .o_vec_data,
        .o_vec_oe_n, .o_cas_addr);
    cdic_cpu_model cpu (.i_sys_clk, .i_rst_n, .i_en(en), .i_slow(slow),
        .i_spur(spur), .i_cpu_irq(o_cpu_irq), .o_ack(i_ack));
    task automatic cmp_val(input logic [7:0] g, input logic [7:0] e,
                           input string m);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h",
                     $time, m, g, e);
        end
    endtask : cmp_val
    task automatic final_report;
        $display("Checks made %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    // A read notes its expected byte; the watcher below compares it.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        if (!w) rq.push_back(d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= w;
        i_rd <= !w;
        @(posedge i_sys_clk);
        {i_wr, i_rd} <= 2'b00;
        @(posedge i_sys_clk);
    endtask : bus
    task automatic init(input logic [7:0] a, input logic [7:0] v,
                        input logic [7:0] c, input logic [7:0] m);
        bus(1'b1, a, 8'h10);
        bus(1'b1, a | 8'h01, v);
        bus(1'b1, a | 8'h01, c);
        bus(1'b1, a | 8'h01, m);
    endtask : init
    task automatic waitv;
        for (int k = 0; k < 60 && vq.size() != 0; k++) begin
            @(posedge i_sys_clk);
        end
        cmp_val(8'(vq.size()), 8'h00, "vector missing");
        vq.delete();
    endtask : waitv
    task automatic svc(input int b, input logic [7:0] e);
        vq.push_back(e);
        if (b < 0) spur <= 1'b1;
        else req_q[b] <= 1'b1;
        @(posedge i_sys_clk);
        spur <= 1'b0;
        waitv();
        if (b >= 0) req_q[b] <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
    endtask : svc
    always @(posedge i_sys_clk) begin
        if (rd_q) cmp_val(o_rdata, rq.pop_front(), "read data");
        rd_q <= i_rd;
        if (i_rst_n && o_vec_oe_n === 1'b0) begin
            if (vq.size() == 0) begin
                miscompares++;
                $display("CHECK FAILED at %0t: unexpected vector", $time);
            end else begin
                cmp_val(o_vec_data, vq.pop_front(), "vector");
            end
        end
    end
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        repeat (5000) @(posedge i_sys_clk);
        miscompares++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        {i_rst_n, i_wr, i_rd, en, slow, spur} = '0;
        {i_addr, i_wdata} = '0;
        req_q = '0;
        mb = 8'($random(seed)) & 8'hF8;
        sb = 8'($random(seed)) & 8'hF8;
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        init(8'h20, mb, 8'h04, 8'h02);
        init(8'hA0, sb, 8'h02, 8'h02);
        en <= 1'b1;
        bus(1'b1, 8'h21, 8'hFB);
        bus(1'b1, 8'h22, 8'h00);
        bus(1'b0, 8'h21, 8'hFB);
        bus(1'b0, 8'h40, 8'h00);
        bus(1'b0, 8'hA1, 8'h00);
        req_q[6] <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        cmp_val({7'h00, o_cpu_irq}, 8'h00, "masked request");
        vq.push_back(mb | 8'h06);
        bus(1'b1, 8'h21, 8'h00);
        waitv();
        req_q[6] <= 1'b0;
        bus(1'b1, 8'h20, 8'h20);
        $display("Test mask and decode finished");
        svc(3, mb | 8'h03);
        req_q[5] <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        cmp_val({7'h00, o_cpu_irq}, 8'h00, "blocked request");
        svc(1, mb | 8'h01);
        bus(1'b1, 8'h20, 8'h0B);
        bus(1'b0, 8'h20, 8'h0A);
        bus(1'b1, 8'h20, 8'h20);
        bus(1'b0, 8'h20, 8'h08);
        vq.push_back(mb | 8'h05);
        bus(1'b1, 8'h20, 8'h63);
        waitv();
        req_q[5] <= 1'b0;
        bus(1'b1, 8'h20, 8'h20);
        bus(1'b0, 8'h20, 8'h00);
        $display("Test nesting and end commands finished");
        svc(9, sb | 8'h01);
        cmp_val({5'h00, o_cas_addr}, 8'h02, "cascade code");
        bus(1'b1, 8'hA0, 8'h20);
        bus(1'b1, 8'h20, 8'h20);
        svc(16, mb);
        bus(1'b1, 8'h20, 8'h20);
        svc(17, sb);
        bus(1'b1, 8'hA0, 8'h20);
        bus(1'b1, 8'h20, 8'h20);
        $display("Test cascade and fixed sources finished");
        svc(-1, mb | 8'h07);
        $display("Test spurious acknowledge finished");
        // A masked in-service bit outlives a non-specific end in special
        // mask mode, so only a specific end can retire it.
        svc(3, mb | 8'h03);
        bus(1'b1, 8'h20, 8'h68);
        bus(1'b1, 8'h21, 8'h08);
        bus(1'b1, 8'h20, 8'h20);
        bus(1'b0, 8'h20, 8'h08);
        bus(1'b1, 8'h20, 8'hE3);
        bus(1'b0, 8'h20, 8'h00);
        bus(1'b1, 8'h20, 8'h48);
        bus(1'b1, 8'h21, 8'h00);
        $display("Test special mask and rotating end finished");
        // Slow acknowledges, automatic end and a new lowest channel.
        slow <= 1'b1;
        init(8'h20, mb, 8'h04, 8'h00);
        bus(1'b1, 8'h20, 8'hC3);
        vq.push_back(mb | 8'h05);
        vq.push_back(mb | 8'h01);
        req_q <= 18'h00022;
        waitv();
        req_q <= '0;
        $display("Test automatic end and priority change finished");
        final_report();
    end
endmodule : cdic_top_tb_top
`default_nettype wire
